// ### rtl/elsw_map.svh
// register offsets, field positions and reset values of the byte lane swapper
`ifndef ELSW_MAP_SVH
`define ELSW_MAP_SVH
// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define ELSW_CTRL_OFS       12'h234   // board memory and swap control
`define ELSW_STAT_OFS       12'h238   // swap stage status
`define ELSW_SEL_LO_BIT     6         // first selection bit
`define ELSW_SEL_HI_BIT     7         // second selection bit
`define ELSW_CTRL_RST       8'hC0     // straight-through after reset
`endif

// ### rtl/elsw_pkg.sv
// types shared by the byte lane swapper files
package elsw_pkg;
    // ------------------------------------------------------------------------
    // lane ordering mode decoded from the two selection bits
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ELSW_MODE_STRAIGHT,   // both bits set
        ELSW_MODE_SWAP,       // both bits clear
        ELSW_MODE_MIXED       // bits disagree: undefined, treated as straight
    } elsw_mode_t;
    // ------------------------------------------------------------------------
    // transfer size of one word on the path
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ELSW_SIZE_BYTE,
        ELSW_SIZE_HALF,
        ELSW_SIZE_WORD
    } elsw_size_t;
endpackage

// ### rtl/elsw_skid.sv
// two-entry valid/ready buffer in the data path
`timescale 1ns/1ps
module elsw_skid #(
    parameter int WIDTH = 40          // payload width
) (
    input  wire logic             mclk_i,    // system clock
    input  wire logic             arst_n_i,  // async reset, active low
    input  wire logic             s_valid_i, // fill side valid
    output logic                  s_ready_o, // fill side ready
    input  wire logic [WIDTH-1:0] s_data_i,  // fill side payload
    output logic                  m_valid_o, // drain side valid
    input  wire logic             m_ready_i, // drain side ready
    output logic [WIDTH-1:0]      m_data_o   // drain side payload
);
    // ------------------------------------------------------------------------
    // storage: two slots in a ring, count tracks occupancy
    // ------------------------------------------------------------------------
    logic [WIDTH-1:0] mem [2];        // entry array
    logic             wp;             // write slot
    logic             rp;             // read slot
    logic [1:0]       cnt;            // occupancy 0..2
    logic             rdy;            // registered room flag, mirrors cnt != 2
    wire              push = s_valid_i && rdy;
    wire              pop  = (cnt != 2'h0) && m_ready_i;
    wire  [1:0]       next_cnt = cnt + {1'b0, push} - {1'b0, pop};

    // ready comes from its own flop so the fill side sees no decode path
    assign s_ready_o = rdy;
    assign m_valid_o = (cnt != 2'h0);
    assign m_data_o  = mem[rp];

    // ------------------------------------------------------------------------
    // pointer and count update
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
            rdy <= 1'b1;
        end else begin
            if (push) wp <= ~wp;
            if (pop)  rp <= ~rp;
            cnt <= next_cnt;
            rdy <= (next_cnt != 2'h2);
        end
    end

    // data slots hold no reset; valid gating covers them
    always_ff @(posedge mclk_i) begin
        if (push) mem[wp] <= s_data_i;
    end
endmodule

// ### rtl/elsw_top.sv
// byte lane swapper between the bridge side and the VMEbus side
// Function
// - both bits set: bytes keep their lanes
// - both bits clear: swap buffers reverse bytes
// - swap toward VMEbus keeps per-address bytes
// - swap undoes the bridge lane exchange
// - straight mode: misaligned access is undefined
// - VMEbus big-endian, bridge side little-endian
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "elsw_map.svh"
module elsw_top #(
    parameter int DW = 32             // data width in bits
) (
    input  wire logic          mclk_i,      // 200 MHz system clock
    input  wire logic          arst_n_i,    // async reset, active low
    input  wire logic [11:0]   reg_addr_i,  // register address
    input  wire logic [7:0]    reg_wdata_i, // register write data
    input  wire logic          reg_wr_i,    // write strobe
    input  wire logic          reg_rd_i,    // read strobe
    output logic [7:0]         reg_rdata_o, // read data, cycle after strobe
    input  wire logic          in_valid_i,  // bridge side word valid
    output logic               in_ready_o,  // bridge side ready
    input  wire logic [DW-1:0] in_data_i,   // bridge side data lanes
    input  wire logic [1:0]    in_size_i,   // 0 byte, 1 half, 2 word
    input  wire logic [1:0]    in_addr_i,   // low address bits of the access
    output logic               out_valid_o, // VMEbus side word valid
    input  wire logic          out_ready_i, // VMEbus side ready
    output logic [DW-1:0]      out_data_o,  // VMEbus side data lanes
    output logic               swap_o,      // swap mode active
    output logic               misalign_o   // last word misaligned in straight mode
);
    // ------------------------------------------------------------------------
    // control register and mode decode
    // ------------------------------------------------------------------------
    logic [7:0] ctrl;                 // board memory and swap control
    logic       misalign_seen;        // sticky misalign flag
    wire        sel_lo   = ctrl[`ELSW_SEL_LO_BIT];
    wire        sel_hi   = ctrl[`ELSW_SEL_HI_BIT];
    wire        hit_ctrl = (reg_addr_i == `ELSW_CTRL_OFS);
    wire        hit_stat = (reg_addr_i == `ELSW_STAT_OFS);
    // mixed settings are undefined; straight is the safe choice
    wire elsw_pkg::elsw_mode_t mode =
        (sel_lo && sel_hi)   ? elsw_pkg::ELSW_MODE_STRAIGHT :
        (!sel_lo && !sel_hi) ? elsw_pkg::ELSW_MODE_SWAP :
                               elsw_pkg::ELSW_MODE_MIXED;
    wire swap_en = (mode == elsw_pkg::ELSW_MODE_SWAP);

    // ------------------------------------------------------------------------
    // lane reversal; bridge lane 0 is the least significant byte
    // ------------------------------------------------------------------------
    localparam int NB = DW / 8;       // byte lanes
    logic [DW-1:0] rev_word;          // all lanes reversed
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_lane
            assign rev_word[8*g +: 8] = in_data_i[8*(NB-1-g) +: 8];
        end
    endgenerate
    // half word: exchange the two lanes within each half, whatever the address
    wire [DW-1:0] rev_half = {in_data_i[23:16], in_data_i[31:24],
                              in_data_i[7:0],   in_data_i[15:8]};
    wire elsw_pkg::elsw_size_t sz = elsw_pkg::elsw_size_t'(in_size_i);
    // swapping toward the VMEbus cancels the bridge's lane exchange so
    // strings land byte-for-byte at the same addresses
    wire [DW-1:0] swapped =
        (sz == elsw_pkg::ELSW_SIZE_WORD) ? rev_word :
        (sz == elsw_pkg::ELSW_SIZE_HALF) ? rev_half : in_data_i;
    wire [DW-1:0] next_lanes = swap_en ? swapped : in_data_i;
    // straight mode does not define unaligned wide accesses; flag them
    wire next_mis = !swap_en && (
        ((sz == elsw_pkg::ELSW_SIZE_HALF) && in_addr_i[0]) ||
        ((sz == elsw_pkg::ELSW_SIZE_WORD) && (in_addr_i != 2'h0)));

    // ------------------------------------------------------------------------
    // buffer between the lane network and the output register
    // ------------------------------------------------------------------------
    logic          b_valid;           // buffer drain valid
    logic [DW:0]   b_data;            // {misalign, lanes}
    wire           o_free = !out_valid_o || out_ready_i;
    elsw_skid #(.WIDTH(DW + 1)) u_buf (
        .mclk_i    (mclk_i),
        .arst_n_i  (arst_n_i),
        .s_valid_i (in_valid_i),
        .s_ready_o (in_ready_o),
        .s_data_i  ({next_mis, next_lanes}),
        .m_valid_o (b_valid),
        .m_ready_i (o_free),
        .m_data_o  (b_data)
    );
    wire take = b_valid && o_free;

    // ------------------------------------------------------------------------
    // output register: every output from a flip-flop
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
            misalign_o  <= 1'b0;
        end else if (o_free) begin
            out_valid_o <= b_valid;
            if (take) begin
                out_data_o <= b_data[DW-1:0];
                misalign_o <= b_data[DW];
            end
        end
    end

    // ------------------------------------------------------------------------
    // register writes; misalign sticky, set wins over clear
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl          <= `ELSW_CTRL_RST;
            misalign_seen <= 1'b0;
            swap_o        <= 1'b0;
        end else begin
            if (reg_wr_i && hit_ctrl) ctrl <= reg_wdata_i;
            if (take && b_data[DW])                  misalign_seen <= 1'b1;
            else if (reg_wr_i && hit_stat && reg_wdata_i[0]) misalign_seen <= 1'b0;
            swap_o <= swap_en;
        end
    end

    // ------------------------------------------------------------------------
    // read data, valid only in the cycle after the strobe; unmapped reads zero
    // ------------------------------------------------------------------------
    wire [7:0] rd_mux = hit_ctrl ? ctrl :
                        hit_stat ? {5'h00, mode == elsw_pkg::ELSW_MODE_MIXED, swap_en, misalign_seen} :
                                   8'h00;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) reg_rdata_o <= 8'h00;
        else           reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_straight;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (in_valid_i && in_ready_o && ctrl[7:6] == 2'h3) |-> (next_lanes == in_data_i);
    endproperty
    a_straight: assert property (p_straight) else $error("straight mode moved a lane");
    property p_swap_word;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl[7:6] == 2'h0 && in_size_i == 2'h2) |->
            (next_lanes[7:0] == in_data_i[31:24] && next_lanes[15:8] == in_data_i[23:16]);
    endproperty
    a_swap_word: assert property (p_swap_word) else $error("word swap wrong");
    property p_swap_half;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl[7:6] == 2'h0 && in_size_i == 2'h1) |-> (next_lanes[15:0] == {in_data_i[7:0], in_data_i[15:8]});
    endproperty
    a_swap_half: assert property (p_swap_half) else $error("half swap wrong");
    property p_swap_flag;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl[7:6] == 2'h0) |=> swap_o;
    endproperty
    a_swap_flag: assert property (p_swap_flag) else $error("swap flag late");
    property p_involution;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (swap_en && in_size_i == 2'h2) |-> (next_lanes[31:24] == in_data_i[7:0]);
    endproperty
    a_involution: assert property (p_involution) else $error("lane 3 not from lane 0");
    property p_mis;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (take && b_data[DW]) |=> (misalign_o && misalign_seen);
    endproperty
    a_mis: assert property (p_mis) else $error("misalign not reported");
    property p_hold;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o));
    endproperty
    a_hold: assert property (p_hold) else $error("output dropped under stall");
    property p_rd;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (reg_rd_i && hit_ctrl) |=> (reg_rdata_o == $past(ctrl));
    endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
    // a swapped word lands fully reversed, lane by lane
    property p_swap_lanes;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (swap_en && in_size_i == 2'h2) |->
            (next_lanes == {in_data_i[7:0], in_data_i[15:8], in_data_i[23:16], in_data_i[31:24]});
    endproperty
    a_swap_lanes: assert property (p_swap_lanes) else $error("word lanes not reversed");
    // single bytes already sit at their own address, so they pass untouched
    property p_byte_keep;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (swap_en && in_size_i == 2'h0) |-> (next_lanes == in_data_i);
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte moved in swap mode");
    // straight setting must drop the swap indication one cycle later
    property p_straight_flag;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl[7:6] == 2'h3) |=> !swap_o;
    endproperty
    a_straight_flag: assert property (p_straight_flag) else $error("swap flag stuck");
    // swap mode has no alignment limit, so it never flags
    property p_swap_no_mis;
        @(posedge mclk_i) disable iff (!arst_n_i)
        swap_en |-> !next_mis;
    endproperty
    a_swap_no_mis: assert property (p_swap_no_mis) else $error("misalign flagged in swap mode");
    // an unaligned word outside swap mode is always caught
    property p_wide_unaligned;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (!swap_en && in_size_i == 2'h2 && in_addr_i != 2'h0) |-> next_mis;
    endproperty
    a_wide_unaligned: assert property (p_wide_unaligned) else $error("unaligned word not flagged");
    // a clear with no new event leaves the sticky flag low
    property p_mis_clear;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (reg_wr_i && hit_stat && reg_wdata_i[0] && !(take && b_data[DW])) |=> !misalign_seen;
    endproperty
    a_mis_clear: assert property (p_mis_clear) else $error("misalign flag not cleared");
    // status read shows the swap state of the strobe cycle
    property p_stat_swap;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (reg_rd_i && hit_stat) |=> (reg_rdata_o[1] == $past(swap_en));
    endproperty
    a_stat_swap: assert property (p_stat_swap) else $error("status swap bit wrong");
endmodule

// ### tb/elsw_far_model.sv
// far side sink model that answers the stage's VMEbus side with ready
`timescale 1ns/1ps
module elsw_far_model (
    input  wire logic mclk_i,   // system clock
    input  wire logic arst_n_i, // async reset, active low
    input  wire logic stall_i,  // hold ready low to fill the buffer
    input  wire logic slow_i,   // ready only on every other cycle
    output logic      ready_o   // ready toward the stage
);
    // --------------------------------------------------------------------
    // ready pattern
    // --------------------------------------------------------------------
    logic phase; // alternates so a slow answer still drains in bounded time
    // registered ready, so it never follows valid in the same cycle
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase   <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            phase   <= ~phase;
            ready_o <= !stall_i && (!slow_i || phase);
        end
    end
endmodule

// ### tb/elsw_top_tb.sv
// self-checking bench of the byte lane swapper
`timescale 1ns/1ps
`include "elsw_map.svh"
module elsw_top_tb;
    logic mclk_i, arst_n_i, wr, rd, iv, stall, slow; // clock, reset, strobes
    logic [11:0] addr;                // register address
    logic [7:0]  wd, rdat;            // register data
    logic [31:0] idat, odat;          // data lanes
    logic [1:0]  isz, ia;             // size and low address
    logic irdy, ov, ordy, swp, mis;   // handshakes and flags
    logic [32:0] rx_q[$];             // words seen at the far side
    int fail_count = 0;
    int check_count = 0;
    elsw_top u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .in_valid_i(iv), .in_ready_o(irdy),
        .in_data_i(idat), .in_size_i(isz), .in_addr_i(ia), .out_valid_o(ov), .out_ready_i(ordy),
        .out_data_o(odat), .swap_o(swp), .misalign_o(mis));
    elsw_far_model u_far (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .stall_i(stall), .slow_i(slow),
        .ready_o(ordy));
    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // capture each accepted beat with its misalign flag
    always @(posedge mclk_i) if (ov && ordy) rx_q.push_back({mis, odat});
    task automatic tally_and_finish();
        if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a; wd <= d; wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr <= a; rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 chk({25'h0, rdat}, {25'h0, e});
    endtask
    // request held until ready is seen at a rising edge
    task automatic send(input logic [31:0] d, input logic [1:0] s, input logic [1:0] a);
        logic r;
        iv <= 1'b1; idat <= d; isz <= s; ia <= a;
        for (int i = 0; i < 60; i++) begin
            @(negedge mclk_i) r = irdy;
            @(posedge mclk_i);
            if (r) return;
        end
        fail_count++;
        tally_and_finish();
    endtask
    task automatic expect_rx(input logic [32:0] e);
        for (int i = 0; i < 60 && rx_q.size() == 0; i++) @(posedge mclk_i);
        if (rx_q.size() == 0) begin
            fail_count++;
            tally_and_finish();
        end else begin
            chk(rx_q.pop_front(), e);
        end
    endtask
    // --------------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------------
    task automatic t_regs();
        reg_chk(`ELSW_CTRL_OFS, `ELSW_CTRL_RST);
        reg_chk(12'h100, 8'h00);      // unmapped place reads zero
        reg_wr(`ELSW_CTRL_OFS, 8'h40); // bits disagree: straight
        send(32'h01020304, 2'h2, 2'h0);
        iv <= 1'b0;
        expect_rx({1'b0, 32'h01020304});
        reg_wr(12'h100, 8'h00);       // unmapped write is ignored
        reg_chk(`ELSW_CTRL_OFS, 8'h40);
        reg_chk(`ELSW_STAT_OFS, 8'h04);
        reg_wr(`ELSW_CTRL_OFS, 8'hC0);
    endtask
    task automatic t_straight();
        send(32'h12345678, 2'h2, 2'h0);
        send(32'hAABBCCDD, 2'h1, 2'h2);
        iv <= 1'b0;
        expect_rx({1'b0, 32'h12345678});
        expect_rx({1'b0, 32'hAABBCCDD});
        chk({32'h0, swp}, 33'h0);
    endtask
    // slow far side with words of all three sizes back to back
    task automatic t_swap();
        reg_wr(`ELSW_CTRL_OFS, 8'h00);
        slow <= 1'b1;
        send(32'h12345678, 2'h2, 2'h0);
        send(32'h11223344, 2'h1, 2'h0);
        send(32'h11223344, 2'h0, 2'h0);
        iv <= 1'b0;
        expect_rx({1'b0, 32'h78563412});
        expect_rx({1'b0, 32'h22114433});
        expect_rx({1'b0, 32'h11223344});
        chk({32'h0, swp}, 33'h1);
        reg_chk(`ELSW_STAT_OFS, 8'h02);
        slow <= 1'b0;
    endtask
    // unaligned word in straight mode is flagged, sticky until cleared
    task automatic t_misalign();
        reg_wr(`ELSW_CTRL_OFS, 8'hC0);
        send(32'hCAFE0102, 2'h2, 2'h1);
        iv <= 1'b0;
        expect_rx({1'b1, 32'hCAFE0102});
        reg_chk(`ELSW_STAT_OFS, 8'h01);
        reg_wr(`ELSW_STAT_OFS, 8'h01);
        reg_chk(`ELSW_STAT_OFS, 8'h00);
    endtask
    // stalled far side: buffer refuses, then drains with no word lost
    task automatic t_stall();
        @(posedge mclk_i);
        stall <= 1'b1;
        fork
            begin
                for (int k = 0; k < 4; k++) send(32'h0A0B0C00 + k, 2'h2, 2'h0);
                iv <= 1'b0;
            end
            begin
                repeat (12) @(posedge mclk_i);
                #1 chk({32'h0, irdy}, 33'h0);
                @(posedge mclk_i) stall <= 1'b0;
            end
        join
        for (int k = 0; k < 4; k++) expect_rx({1'b0, 32'h0A0B0C00 + k});
    endtask
    initial begin
        arst_n_i = 1'b0; wr = 1'b0; rd = 1'b0; iv = 1'b0; stall = 1'b0; slow = 1'b0;
        addr = 12'h000; wd = 8'h00; idat = 32'h0; isz = 2'h0; ia = 2'h0;
        repeat (20) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        t_regs();
        t_straight();
        t_swap();
        t_misalign();
        t_stall();
        tally_and_finish();
    end
endmodule
